/* File: shared/sfl_params.svh */
// Constants for the synthesizer latch and power-down control block
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH
`define SFL_WORD_BITS    24
`define SFL_LATCH_RST    24'h000000
`define SFL_DEST_CTRL    2'h0
`define SFL_DEST_REF     2'h1
`define SFL_DEST_NCNT    2'h2
`define SFL_DEST_TEST    2'h3
`define SFL_SYNC_EDGES   2'h2
`define SFL_LOCK_FAST    3'h3
`define SFL_LOCK_PRECISE 3'h5
`endif

/* File: shared/sfl_pkg.sv */
// Types for the synthesizer latch and power-down control block
package sfl_pkg;
    // Control latch layout, MSB first
    typedef struct packed {
        logic       prescale_sel_hi;
        logic       prescale_sel_lo;
        logic       pwrdn_sync_sel;
        logic       pwrdn_arm;
        logic [2:0] pump_current_two_sel;
        logic [2:0] pump_current_one_sel;
        logic       out_level_hi;
        logic       out_level_lo;
        logic       mute_until_locked;
        logic       pump_gain_sel;
        logic       pump_tristate;
        logic       pd_polarity;
        logic [2:0] mux_sel;
        logic       counter_reset;
        logic [1:0] core_level;
        logic       dest_sel_hi;
        logic       dest_sel_lo;
    } sfl_ctrl_s;
    // Reference divider latch layout
    typedef struct packed {
        logic [1:0]  reserved;
        logic        band_clk_div_hi;
        logic        band_clk_div_lo;
        logic        factory_test_flag;
        logic        lock_precision_sel;
        logic        antibacklash_width_hi;
        logic        antibacklash_width_lo;
        logic [13:0] ref_count;
        logic        dest_sel_hi;
        logic        dest_sel_lo;
    } sfl_ref_s;
    // N counter latch layout
    typedef struct packed {
        logic        div2_sel;
        logic        div2;
        logic        pump_gain;
        logic [12:0] b_count;
        logic        reserved;
        logic [4:0]  a_count;
        logic        dest_sel_hi;
        logic        dest_sel_lo;
    } sfl_ncnt_s;
    // Power-down effects driven to the rest of the chip
    typedef struct packed {
        logic powered_down;
        logic counter_load;
        logic pump_tristate;
        logic lock_rst;
        logic rf_out_en;
        logic ref_buf_en;
    } sfl_pd_s;
    // Power sequencing states
    typedef enum logic [1:0] {
        PS_INIT_PD,
        PS_RUN,
        PS_SYNC_WAIT,
        PS_SOFT_PD
    } sfl_pwr_e;
endpackage

/* File: verif/sfl_host.sv */
// Host model that shifts words into the serial pins
`timescale 1ns/10ps
module sfl_host (
    input  wire logic i_sys_clk,
    output logic      o_ser_clk,
    output logic      o_ser_data,
    output logic      o_load_strobe
);
    // Pins start low; the link clock stands still between words
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_load_strobe = 1'b0;
    end
    // Each level held 4 cycles, past the 2FF synchroniser need
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge i_sys_clk) o_ser_data = w[i]; // MSB first
            repeat (4) @(negedge i_sys_clk);
            o_ser_clk = 1'b1;
            repeat (4) @(negedge i_sys_clk);
            o_ser_clk = 1'b0;
        end
        o_ser_data = ~w[0]; // Released data shows no stale level
        repeat (3) @(negedge i_sys_clk);
        o_load_strobe = 1'b1; // Commit on strobe rise
        repeat (4) @(negedge i_sys_clk);
        o_load_strobe = 1'b0;
        repeat (8) @(negedge i_sys_clk);
    endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the latch and power-down block
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic refo = 1'b0;
    logic tick = 1'b0;
    logic es = 1'b0;
    logic el = 1'b0;
    logic sck, sd, le, lk, pg, bt, bsr;
    sfl_pkg::sfl_pd_s pd;
    sfl_pkg::sfl_ncnt_s nc;
    sfl_pkg::sfl_ctrl_s ctl;
    sfl_pkg::sfl_ref_s rf;
    logic [2:0] cur;
    logic [1:0] pre, lvl;
    logic [23:0] tw, c;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int bt_n = 0;
    int bsr_n = 0;
    int tick_mark = 0;
    localparam int SETTLE_CYC = 60000; // 600 us control-to-N wait at 10 ns
    integer seed = 32'h98d30397;
    always #5 clk = ~clk;
    sfl_host u_host (.i_sys_clk(clk), .o_ser_clk(sck), .o_ser_data(sd), .o_load_strobe(le));
    sfl_latch_ctrl u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_ser_clk(sck), .i_ser_data(sd),
        .i_load_strobe(le), .i_chip_en(ce), .i_ref_cnt_out(refo), .i_pfd_tick(tick),
        .i_phase_err_small(es), .i_phase_err_large(el), .o_pd(pd), .o_ctrl(ctl), .o_ref(rf),
        .o_ncnt(nc), .o_pump_current(cur), .o_pump_gain(pg), .o_prescale_sel(pre), .o_out_level(lvl),
        .o_band_clk_tick(bt), .o_band_sel_req(bsr), .o_lock_detect(lk), .o_test_word(tw));
    // One-cycle pulses counted mid-cycle, where they stand settled
    always @(negedge clk) begin
        if (bt === 1'b1) begin
            bt_n++;
        end
        if (bsr === 1'b1) begin
            bsr_n++;
        end
    end
    // Case equality so an unknown never matches
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One reference counter output pulse, 4 cycles high
    task automatic pulse_ref;
        refo = 1'b1;
        repeat (4) @(negedge clk);
        refo = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Phase detector ticks, then room for lock to reach the outputs
    task automatic pfd_ticks(input int k);
        repeat (k) begin
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            @(negedge clk);
        end
        repeat (3) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard, above the ~63600 cycles that the settling wait dominates
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        u_host.send(24'h000011); // Reference latch first, reserved and test bits zero
        chk("ref", 24'h000011, rf);
        chk("test", 24'h0, tw);
        // Random control words; power-down, mute, tristate, reset cleared
        repeat (4) begin
            c = 24'($random(seed)) & 24'hCFF5EC;
            u_host.send(c);
            chk("ctrl", c, ctl);
            chk("pd", 6'b000011, pd);
            chk("cur", c[10] ? c[19:17] : c[16:14], cur);
            chk("pre_lvl", {c[23:22], c[13:12]}, {pre, lvl});
        end
        $display("test latches done");
        u_host.send(c | 24'h100000);
        chk("pd_async", 6'b111100, pd);
        u_host.send(24'h000015);
        chk("ref_down", 24'h000015, rf);
        u_host.send(c);
        chk("pd_up", 6'b000011, pd);
        u_host.send(c | 24'h300000);
        pulse_ref();
        chk("sync1", 1'b0, pd.powered_down);
        pulse_ref();
        chk("sync2", 1'b1, pd.powered_down);
        u_host.send(c);
        ce = 1'b0;
        repeat (4) @(negedge clk);
        chk("ce_low", 1'b1, pd.powered_down);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        chk("ce_high", 1'b0, pd.powered_down);
        $display("test power-down done");
        u_host.send(c | 24'h000800);
        chk("muted", 1'b0, pd.rf_out_en);
        es = 1'b1;
        pfd_ticks(3);
        chk("lock", 1'b1, lk);
        chk("unmuted", 1'b1, pd.rf_out_en);
        // Band clock divide by 8 and precise lock; a power-down clears lock first
        u_host.send(24'h340015);
        chk("ref_band", 24'h340015, rf);
        u_host.send(c | 24'h100800);
        chk("lock_rst", 1'b0, lk);
        u_host.send(c | 24'h000A00);
        chk("tristate", 1'b1, pd.pump_tristate);
        chk("muted_again", 1'b0, pd.rf_out_en);
        tick_mark = bt_n;
        repeat (7) pulse_ref();
        chk("band_early", 24'h0, 24'(bt_n - tick_mark));
        pulse_ref();
        chk("band_tick", 24'h1, 24'(bt_n - tick_mark));
        pfd_ticks(4);
        chk("lock_4", 1'b0, lk);
        pfd_ticks(1);
        chk("lock_5", 1'b1, lk);
        es = 1'b0;
        el = 1'b1;
        pfd_ticks(1);
        chk("unlock", 1'b0, lk);
        $display("test lock done");
        // N latch last, after the settling wait, and never while powered down
        chk("no_reselect", 24'h0, 24'(bsr_n));
        repeat (SETTLE_CYC) @(negedge clk);
        u_host.send(24'h200002);
        chk("ncnt", 24'h200002, nc);
        chk("band_sel", 24'h1, 24'(bsr_n));
        chk("gain_n", 1'b1, pg);
        chk("cur_n", c[19:17], cur);
        $display("test N latch done");
        give_verdict();
    end
endmodule

/* File: verilog/sfl_latch_ctrl.sv */
// Latch bank and power sequencing for the integer-N synthesizer digital core
`timescale 1ns/10ps
`include "sfl_params.svh"
module sfl_latch_ctrl (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_ser_clk,
    input  wire logic                   i_ser_data,
    input  wire logic                   i_load_strobe,
    input  wire logic                   i_chip_en,
    input  wire logic                   i_ref_cnt_out,
    input  wire logic                   i_pfd_tick,
    input  wire logic                   i_phase_err_small,
    input  wire logic                   i_phase_err_large,
    output sfl_pkg::sfl_pd_s            o_pd,
    output sfl_pkg::sfl_ctrl_s          o_ctrl,
    output sfl_pkg::sfl_ref_s           o_ref,
    output sfl_pkg::sfl_ncnt_s          o_ncnt,
    output logic [2:0]                  o_pump_current,
    output logic                        o_pump_gain,
    output logic [1:0]                  o_prescale_sel,
    output logic [1:0]                  o_out_level,
    output logic                        o_band_clk_tick,
    output logic                        o_band_sel_req,
    output logic                        o_lock_detect,
    output logic [`SFL_WORD_BITS-1:0]   o_test_word
);
    logic [`SFL_WORD_BITS-1:0] word;          // Last received word
    logic                      commit;        // One-cycle commit pulse
    logic [1:0]                dest;          // Destination select of word
    sfl_pkg::sfl_ctrl_s        wctrl;         // Word viewed as control latch
    sfl_pkg::sfl_ref_s         ctrl_ref_view; // Word viewed as reference latch
    sfl_pkg::sfl_ncnt_s        wncnt;         // Word viewed as N latch
    sfl_pkg::sfl_ctrl_s        ctrl_ff;       // Control latch
    sfl_pkg::sfl_ref_s         ref_ff;        // Reference divider latch
    sfl_pkg::sfl_ncnt_s        ncnt_ff;       // N counter latch
    logic [`SFL_WORD_BITS-1:0] test_ff;       // Factory test latch
    logic                      gain_ff;       // Latest written pump gain
    logic [1:0]                ce_sync_ff;    // Chip enable synchroniser
    logic                      ce_s;          // Synchronised chip enable
    logic                      ref_prev_ff;   // Reference output last cycle
    logic                      ref_rise;      // Reference output rising
    logic [1:0]                sync_cnt_ff;   // Reference edges since strobe
    logic [2:0]                band_cnt_ff;   // Band clock divider count
    sfl_pkg::sfl_pwr_e         state_ff;      // Power sequencing state
    sfl_pkg::sfl_pwr_e         nxt_state;
    logic                      nxt_down;      // Device will be powered down
    logic                      locked;        // Lock detector output
    sfl_pkg::sfl_ctrl_s        ctrl_eff;      // Control bits in force, a write this cycle included
    logic                      ctrl_hit;      // Control commit this cycle, any state

    // Selects for one of the four latches
    function automatic logic fn_hit(input logic [1:0] d, input logic [1:0] code);
        fn_hit = (d == code);
    endfunction

    // Last count value of the 1/2/4/8 band clock divider
    function automatic logic [2:0] fn_div_last(input logic hi, input logic lo);
        fn_div_last = 3'(({hi, lo} == 2'h0) ? 3'h0 : ((3'h1 << {hi, lo}) - 3'h1));
    endfunction

    sfl_shift_in u_shift (
        .i_sys_clk     (i_sys_clk),
        .i_nrst        (i_nrst),
        .i_ser_clk     (i_ser_clk),
        .i_ser_data    (i_ser_data),
        .i_load_strobe (i_load_strobe),
        .o_word        (word),
        .o_commit      (commit)
    );

    sfl_lock_detect u_lock (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_clear     (o_pd.lock_rst),
        .i_precise   (ref_ff.lock_precision_sel),
        .i_pfd_tick  (i_pfd_tick),
        .i_err_small (i_phase_err_small),
        .i_err_large (i_phase_err_large),
        .o_locked    (locked)
    );

    assign wctrl         = sfl_pkg::sfl_ctrl_s'(word);
    assign ctrl_ref_view = sfl_pkg::sfl_ref_s'(word);
    assign wncnt         = sfl_pkg::sfl_ncnt_s'(word);
    assign dest          = {wctrl.dest_sel_hi, wctrl.dest_sel_lo};
    assign ctrl_hit      = commit & fn_hit(dest, `SFL_DEST_CTRL);
    assign ctrl_eff      = ctrl_hit ? wctrl : ctrl_ff;
    assign ce_s          = ce_sync_ff[1];
    assign ref_rise      = i_ref_cnt_out & ~ref_prev_ff;

    // Chip enable is a pin: two stages before use
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ce_sync_ff  <= 2'h0;
            ref_prev_ff <= 1'b0;
        end else begin
            ce_sync_ff  <= {ce_sync_ff[0], i_chip_en};
            ref_prev_ff <= i_ref_cnt_out;
        end
    end

    // Latch commits; loads are taken even while powered down
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ff <= sfl_pkg::sfl_ctrl_s'(`SFL_LATCH_RST);
            ref_ff  <= sfl_pkg::sfl_ref_s'(`SFL_LATCH_RST);
            ncnt_ff <= sfl_pkg::sfl_ncnt_s'(`SFL_LATCH_RST);
            test_ff <= `SFL_LATCH_RST;
        end else if (commit) begin
            if (fn_hit(dest, `SFL_DEST_CTRL)) begin
                ctrl_ff <= wctrl;
            end
            if (fn_hit(dest, `SFL_DEST_REF)) begin
                ref_ff <= ctrl_ref_view;
            end
            if (fn_hit(dest, `SFL_DEST_NCNT)) begin
                ncnt_ff <= wncnt;
            end
            if (fn_hit(dest, `SFL_DEST_TEST)) begin
                test_ff <= word;
            end
        end
    end

    // Pump gain follows whichever latch wrote it last
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gain_ff <= 1'b0;
        end else if (commit && fn_hit(dest, `SFL_DEST_CTRL)) begin
            gain_ff <= wctrl.pump_gain_sel;
        end else if (commit && fn_hit(dest, `SFL_DEST_NCNT)) begin
            gain_ff <= wncnt.pump_gain;
        end
    end

    // Power sequencing decision
    always_comb begin
        nxt_state = state_ff;
        if (ctrl_hit) begin
            // A control write re-decides the mode from its two bits; a synchronous request starts the wait only from PS_RUN
            if (!wctrl.pwrdn_arm) begin
                nxt_state = sfl_pkg::PS_RUN;
            end else if (!wctrl.pwrdn_sync_sel) begin
                nxt_state = sfl_pkg::PS_SOFT_PD;
            end else if (state_ff == sfl_pkg::PS_RUN) begin
                nxt_state = sfl_pkg::PS_SYNC_WAIT;
            end
        end else begin
            unique case (state_ff)
                sfl_pkg::PS_INIT_PD: nxt_state = sfl_pkg::PS_INIT_PD;
                sfl_pkg::PS_RUN:     nxt_state = sfl_pkg::PS_RUN;
                sfl_pkg::PS_SYNC_WAIT: begin
                    // Second reference edge after the strobe ends the wait
                    if (ref_rise && (sync_cnt_ff == `SFL_SYNC_EDGES - 2'h1)) begin
                        nxt_state = sfl_pkg::PS_SOFT_PD;
                    end
                end
                sfl_pkg::PS_SOFT_PD: nxt_state = sfl_pkg::PS_SOFT_PD;
            endcase
        end
        // Chip enable low wins over both programmed bits
        nxt_down = !ce_s || (nxt_state == sfl_pkg::PS_INIT_PD) || (nxt_state == sfl_pkg::PS_SOFT_PD);
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= sfl_pkg::PS_INIT_PD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Reference edges counted from the strobe that armed the wait
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_cnt_ff <= 2'h0;
        end else if (state_ff != sfl_pkg::PS_SYNC_WAIT) begin
            sync_cnt_ff <= 2'h0;
        end else if (ref_rise) begin
            sync_cnt_ff <= sync_cnt_ff + 2'h1;
        end
    end

    // Power-down effects, registered so they share one edge
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pd <= '{powered_down: 1'b1, counter_load: 1'b1, pump_tristate: 1'b1,
                      lock_rst: 1'b1, rf_out_en: 1'b0, ref_buf_en: 1'b0};
        end else begin
            o_pd.powered_down  <= nxt_down;
            o_pd.counter_load  <= nxt_down || ctrl_eff.counter_reset;
            o_pd.pump_tristate <= nxt_down || ctrl_eff.pump_tristate;
            o_pd.lock_rst      <= nxt_down;
            o_pd.ref_buf_en    <= !nxt_down;
            // New mute bit counts at once, else RF would glow for a cycle on power-up
            o_pd.rf_out_en     <= !nxt_down && (!ctrl_eff.mute_until_locked || locked);
        end
    end

    // Band clock divider; held at load while down
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            band_cnt_ff     <= 3'h0;
            o_band_clk_tick <= 1'b0;
        end else if (o_pd.powered_down) begin
            band_cnt_ff     <= 3'h0;
            o_band_clk_tick <= 1'b0;
        end else begin
            o_band_clk_tick <= 1'b0;
            if (ref_rise) begin
                if (band_cnt_ff >= fn_div_last(ref_ff.band_clk_div_hi, ref_ff.band_clk_div_lo)) begin
                    band_cnt_ff     <= 3'h0;
                    o_band_clk_tick <= 1'b1;
                end else begin
                    band_cnt_ff <= band_cnt_ff + 3'h1;
                end
            end
        end
    end

    // Band search only on an N write; power-up keeps the old band
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_band_sel_req <= 1'b0;
        end else begin
            o_band_sel_req <= commit && fn_hit(dest, `SFL_DEST_NCNT);
        end
    end

    // Latch contents onto the analog side
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ctrl         <= sfl_pkg::sfl_ctrl_s'(`SFL_LATCH_RST);
            o_ref          <= sfl_pkg::sfl_ref_s'(`SFL_LATCH_RST);
            o_ncnt         <= sfl_pkg::sfl_ncnt_s'(`SFL_LATCH_RST);
            o_pump_current <= 3'h0;
            o_pump_gain    <= 1'b0;
            o_prescale_sel <= 2'h0;
            o_out_level    <= 2'h0;
            o_lock_detect  <= 1'b0;
            o_test_word    <= `SFL_LATCH_RST;
        end else begin
            o_ctrl         <= ctrl_ff;
            o_ref          <= ref_ff;
            o_ncnt         <= ncnt_ff;
            // Gain picks setting two or one
            o_pump_current <= gain_ff ? ctrl_ff.pump_current_two_sel : ctrl_ff.pump_current_one_sel;
            o_pump_gain    <= gain_ff;
            o_prescale_sel <= {ctrl_ff.prescale_sel_hi, ctrl_ff.prescale_sel_lo};
            o_out_level    <= {ctrl_ff.out_level_hi, ctrl_ff.out_level_lo};
            o_lock_detect  <= locked;
            // Test contents are invisible unless the flag is set
            o_test_word    <= ref_ff.factory_test_flag ? test_ff : `SFL_LATCH_RST;
        end
    end

    property p_ctrl_commit;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        ctrl_hit |=> (ctrl_ff == $past(wctrl)) ##1 (o_ctrl == $past(wctrl, 2));
    endproperty
    a_ctrl_commit: assert property (p_ctrl_commit) else $error("control latch not loaded");

    property p_ref_commit;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (commit && dest == `SFL_DEST_REF) |=> (ref_ff == $past(ctrl_ref_view)) && (ctrl_ff == $past(ctrl_ff));
    endproperty
    a_ref_commit: assert property (p_ref_commit) else $error("reference latch not loaded");

    property p_init_up;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == sfl_pkg::PS_INIT_PD && ctrl_hit && !wctrl.pwrdn_arm && ce_s) |=> !o_pd.powered_down;
    endproperty
    a_init_up: assert property (p_init_up) else $error("control write did not power up");

    property p_async_pd;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (ctrl_hit && wctrl.pwrdn_arm && !wctrl.pwrdn_sync_sel) |=> o_pd.powered_down && o_pd.lock_rst;
    endproperty
    a_async_pd: assert property (p_async_pd) else $error("asynchronous power-down late");

    property p_sync_pd;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == sfl_pkg::PS_SYNC_WAIT && ce_s && !commit) |=>
            (o_pd.powered_down == ($past(ref_rise) && ($past(sync_cnt_ff) == `SFL_SYNC_EDGES - 2'h1)));
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("synchronous power-down timing wrong");

    property p_ce_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !ce_s |=> o_pd.powered_down && !o_pd.rf_out_en;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("chip enable low did not disable");

    property p_pd_effects;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_pd.powered_down |-> o_pd.counter_load && o_pd.pump_tristate && o_pd.lock_rst
            && !o_pd.rf_out_en && !o_pd.ref_buf_en;
    endproperty
    a_pd_effects: assert property (p_pd_effects) else $error("power-down effects incomplete");

    property p_mute;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_pd.rf_out_en |-> ($past(locked) || !ctrl_ff.mute_until_locked);
    endproperty
    a_mute: assert property (p_mute) else $error("RF enabled before lock");

    property p_gain;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        ##1 (o_pump_current == ($past(gain_ff) ? $past(ctrl_ff.pump_current_two_sel)
                                               : $past(ctrl_ff.pump_current_one_sel)));
    endproperty
    a_gain: assert property (p_gain) else $error("wrong pump current setting");

    property p_test_hidden;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!ref_ff.factory_test_flag) |=> (o_test_word == `SFL_LATCH_RST);
    endproperty
    a_test_hidden: assert property (p_test_hidden) else $error("test latch leaked");
endmodule

/* File: verilog/sfl_lock_detect.sv */
// Digital lock detector: consecutive small-error cycles, drop on large error
`timescale 1ns/10ps
`include "sfl_params.svh"
module sfl_lock_detect (
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    input  wire logic i_clear,
    input  wire logic i_precise,
    input  wire logic i_pfd_tick,
    input  wire logic i_err_small,
    input  wire logic i_err_large,
    output logic      o_locked
);
    logic [2:0] run_ff;   // Consecutive good cycles, saturating
    logic [2:0] need;     // Cycles needed for lock

    assign need = i_precise ? `SFL_LOCK_PRECISE : `SFL_LOCK_FAST;

    // Count good cycles; a bad one restarts the run
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_ff   <= 3'h0;
            o_locked <= 1'b0;
        end else if (i_clear) begin
            run_ff   <= 3'h0;
            o_locked <= 1'b0;
        end else if (i_pfd_tick) begin
            if (i_err_small) begin
                // Saturate so a long lock does not wrap
                run_ff <= (run_ff == need) ? run_ff : run_ff + 3'h1;
                if (run_ff + 3'h1 >= need) begin
                    o_locked <= 1'b1;
                end
            end else begin
                run_ff <= 3'h0;
                // Once set, only a large error or a clear drops lock
                if (i_err_large) begin
                    o_locked <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: verilog/sfl_shift_in.sv */
// Serial word receiver: pin synchronisers, 24-bit shifter, commit on load strobe
`timescale 1ns/10ps
`include "sfl_params.svh"
module sfl_shift_in (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_ser_clk,
    input  wire logic                      i_ser_data,
    input  wire logic                      i_load_strobe,
    output logic [`SFL_WORD_BITS-1:0]      o_word,
    output logic                           o_commit
);
    logic [2:0]                 clk_sync_ff;  // Stage 0 feeds stage 1 only
    logic [1:0]                 dat_sync_ff;  // Data follows clock by same depth
    logic [2:0]                 le_sync_ff;   // Load strobe synchroniser
    logic [`SFL_WORD_BITS-1:0]  shift_ff;     // Input shift register
    logic                       clk_rise;
    logic                       le_rise;

    // Edges are taken from stages 1 and 2 only
    assign clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
    assign le_rise  = le_sync_ff[1] & ~le_sync_ff[2];

    // Pin synchronisers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_sync_ff <= 3'h0;
            dat_sync_ff <= 2'h0;
            le_sync_ff  <= 3'h0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], i_ser_clk};
            dat_sync_ff <= {dat_sync_ff[0], i_ser_data};
            le_sync_ff  <= {le_sync_ff[1:0], i_load_strobe};
        end
    end

    // MSB first, one bit per serial clock rise; never gated by power-down
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_ff <= `SFL_LATCH_RST;
        end else if (clk_rise) begin
            shift_ff <= {shift_ff[`SFL_WORD_BITS-2:0], dat_sync_ff[1]};
        end
    end

    // Word handed over only on the load strobe rise
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_word   <= `SFL_LATCH_RST;
            o_commit <= 1'b0;
        end else begin
            o_commit <= le_rise;
            if (le_rise) begin
                o_word <= shift_ff;
            end
        end
    end
endmodule
